//--- gebr_pkg.sv
package gebr_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int unsigned max_banks = 2;
   localparam int unsigned bank_bits = 8;
   localparam logic [15:0] bank0_base = 16'h0020;
   localparam logic [15:0] bank1_base = 16'h0024;
   localparam logic [15:0] status_offset = 16'h0000;
   localparam logic [15:0] enable_offset = 16'h0001;
   localparam logic [15:0] lid_control_addr = 16'h0200;
   localparam int unsigned lid_polarity_field = 0;
   localparam int unsigned lid_event_field = 1;
   localparam int unsigned lid_status_bit = 1;

   // ----------------------------------------
   // Reset and answer values
   // ----------------------------------------
   localparam logic [7:0] status_reset = 8'h00;
   localparam logic [7:0] enable_reset = 8'h00;
   localparam logic [7:0] unmapped_read = 8'h00;
   localparam int unsigned sync_stages = 2;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } gebr_io_req_type;

   typedef struct packed {
      logic hit;
      logic lid;
      logic bank;
      logic enable;
   } gebr_sel_type;

endpackage : gebr_pkg

//--- gebr_sync.sv
`timescale 1ns/1ps
module gebr_sync #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // ----------------------------------------
   // Two-stage chain
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
      end
   end

   assign sync_out = stage2;

endmodule : gebr_sync

//--- gebr_general_event.sv
`timescale 1ns/1ps
module gebr_general_event #(
   parameter int unsigned BANKS = 2,
   parameter logic [15:0] EVENT_USED = 16'hfffd
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Byte-wide I/O register port
   input wire gebr_pkg::gebr_io_req_type io_req,
   output logic [7:0] io_rdata,
   // Event sources
   input wire logic [15:0] event_in,
   input wire logic lid_in,
   input wire logic sleeping,
   // System outputs
   output logic power_mgmt_interrupt,
   output logic wake_request
);

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic gebr_pkg::gebr_sel_type decode(input logic [15:0] addr);
      gebr_pkg::gebr_sel_type sel;
      sel = '0;
      if (addr == gebr_pkg::lid_control_addr)
      begin
         sel.hit = 1'b1;
         sel.lid = 1'b1;
      end
      else if (addr == gebr_pkg::bank0_base + gebr_pkg::status_offset)
         sel.hit = 1'b1;
      else if (addr == gebr_pkg::bank0_base + gebr_pkg::enable_offset)
      begin
         sel.hit = 1'b1;
         sel.enable = 1'b1;
      end
      else if (BANKS > 1 && addr == gebr_pkg::bank1_base + gebr_pkg::status_offset)
      begin
         sel.hit = 1'b1;
         sel.bank = 1'b1;
      end
      else if (BANKS > 1 && addr == gebr_pkg::bank1_base + gebr_pkg::enable_offset)
      begin
         sel.hit = 1'b1;
         sel.bank = 1'b1;
         sel.enable = 1'b1;
      end
      return sel;
   endfunction : decode

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic [15:0] event_sync;
   logic [0:0] lid_sync;

   gebr_sync #(.WIDTH(16)) u_event_sync (
      .clock(clock),
      .rst_b(rst_b),
      .async_in(event_in & EVENT_USED),
      .sync_out(event_sync)
   );

   gebr_sync #(.WIDTH(1)) u_lid_sync (
      .clock(clock),
      .rst_b(rst_b),
      .async_in(lid_in),
      .sync_out(lid_sync)
   );

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [1:0][7:0] status;
   logic [1:0][7:0] enable;
   logic lid_polarity;
   logic lid_event_flag;
   logic [1:0] lid_fill;
   logic [1:0] next_lid_fill;
   logic [1:0][7:0] next_status;
   logic [1:0][7:0] next_enable;
   logic next_lid_polarity;
   logic next_lid_event_flag;
   logic [7:0] next_io_rdata;
   logic next_interrupt;
   logic next_wake;
   logic [1:0][7:0] event_active;
   logic lid_active;
   gebr_pkg::gebr_sel_type sel;

   assign sel = decode(io_req.addr);
   // Lid compare waits until the synchroniser holds the real pin level
   assign lid_active = lid_fill[1] && (lid_sync[0] == lid_polarity);

   always_comb
   begin
      event_active = event_sync & EVENT_USED;
      event_active[0][gebr_pkg::lid_status_bit] = lid_event_flag;
      if (BANKS < 2)
         event_active[1] = '0;
   end

   // ----------------------------------------
   // Next-value logic
   // ----------------------------------------
   always_comb
   begin
      next_status = status;
      next_enable = enable;
      next_lid_polarity = lid_polarity;
      next_lid_event_flag = lid_event_flag;
      next_lid_fill = {lid_fill[0], 1'b1};
      if (io_req.wr && sel.hit)
      begin
         if (sel.lid)
         begin
            next_lid_polarity = io_req.wdata[gebr_pkg::lid_polarity_field];
            if (io_req.wdata[gebr_pkg::lid_event_field])
               next_lid_event_flag = 1'b0;
         end
         else if (sel.enable)
            next_enable[sel.bank] = io_req.wdata;
         else
            next_status[sel.bank] = status[sel.bank] & ~io_req.wdata;
      end
      // Set wins over clear
      next_status = next_status | event_active;
      if (lid_active)
         next_lid_event_flag = 1'b1;
      if (BANKS < 2)
      begin
         next_status[1] = '0;
         next_enable[1] = '0;
      end
   end

   always_comb
   begin
      next_io_rdata = io_rdata;
      if (io_req.rd)
      begin
         if (!sel.hit)
            next_io_rdata = gebr_pkg::unmapped_read;
         else if (sel.lid)
            next_io_rdata = {6'h00, lid_event_flag, lid_polarity};
         else if (sel.enable)
            next_io_rdata = enable[sel.bank];
         else
            next_io_rdata = status[sel.bank];
      end
      next_interrupt = |(status & enable);
      next_wake = sleeping && |(status & enable);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         status <= {2{gebr_pkg::status_reset}};
         enable <= {2{gebr_pkg::enable_reset}};
         lid_polarity <= 1'b0;
         lid_event_flag <= 1'b0;
         lid_fill <= 2'h0;
         io_rdata <= 8'h00;
         power_mgmt_interrupt <= 1'b0;
         wake_request <= 1'b0;
      end
      else
      begin
         status <= next_status;
         enable <= next_enable;
         lid_polarity <= next_lid_polarity;
         lid_event_flag <= next_lid_event_flag;
         lid_fill <= next_lid_fill;
         io_rdata <= next_io_rdata;
         power_mgmt_interrupt <= next_interrupt;
         wake_request <= next_wake;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_status_sets: assert property (@(posedge clock) disable iff (!rst_b)
      event_active[0][0] |=> status[0][0])
      else $error("status bit 0 not set by active event");

   a_status_sticky: assert property (@(posedge clock) disable iff (!rst_b)
      (status[0][0] && !(io_req.wr && sel.hit && !sel.lid && !sel.enable && !sel.bank
      && io_req.wdata[0])) |=> status[0][0])
      else $error("status bit cleared without write of one");

   a_w1c_clears: assert property (@(posedge clock) disable iff (!rst_b)
      (io_req.wr && sel.hit && !sel.lid && !sel.enable && !sel.bank && io_req.wdata[2]
      && !event_active[0][2]) |=> !status[0][2])
      else $error("write one did not clear status");

   a_enable_write: assert property (@(posedge clock) disable iff (!rst_b)
      (io_req.wr && sel.hit && sel.enable && !sel.bank) |=> enable[0] == $past(io_req.wdata))
      else $error("enable byte not written");

   a_irq_follows: assert property (@(posedge clock) disable iff (!rst_b)
      (status[0][0] && enable[0][0]) |=> power_mgmt_interrupt)
      else $error("interrupt missing for enabled status");

   a_irq_quiet: assert property (@(posedge clock) disable iff (!rst_b)
      ((status & enable) == '0) |=> !power_mgmt_interrupt)
      else $error("interrupt without enabled status");

   a_wake_sleep: assert property (@(posedge clock) disable iff (!rst_b)
      wake_request |-> $past(sleeping))
      else $error("wake request while awake");

   a_lid_polarity: assert property (@(posedge clock) disable iff (!rst_b)
      (lid_sync[0] && lid_polarity) |=> lid_event_flag ##1 status[0][1])
      else $error("lid flag not feeding bank 0 bit 1");

   a_event_sync: assert property (@(posedge clock) disable iff (!rst_b)
      (!status[0][0] && $rose(event_sync[0])) |-> $past(event_in[0], 2) || !EVENT_USED[0])
      else $error("event bypassed synchroniser");

   a_read_status: assert property (@(posedge clock) disable iff (!rst_b)
      (io_req.rd && sel.hit && !sel.lid && !sel.enable && !sel.bank)
      |=> io_rdata == $past(status[0]))
      else $error("status byte read wrong");

endmodule : gebr_general_event

//--- gebr_event_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Platform event sources
// ----------------------------------------
module gebr_event_src (
   // Commands from the bench
   input wire logic [15:0] pins_set,
   input wire logic lid_open,
   // Pins towards the block
   output logic [15:0] event_in,
   output logic lid_in
);
   // Pin 1 is not wired on this platform, so it is tied inactive
   assign event_in = pins_set & 16'hfffd;
   assign lid_in = lid_open;
endmodule : gebr_event_src

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   gebr_pkg::gebr_io_req_type io_req = '0;
   logic [7:0] io_rdata;
   logic [15:0] pins_set = 16'h0000;
   logic lid_open = 1'b1;
   logic [15:0] event_in;
   logic lid_in;
   logic sleeping = 1'b0;
   logic power_mgmt_interrupt;
   logic wake_request;
   logic [7:0] rd_val;
   int failures = 0;
   int n_compared = 0;

   always #10 clock = ~clock;

   gebr_event_src src_u (
      .pins_set(pins_set),
      .lid_open(lid_open),
      .event_in(event_in),
      .lid_in(lid_in)
   );

   gebr_general_event dut_u (
      .clock(clock),
      .rst_b(rst_b),
      .io_req(io_req),
      .io_rdata(io_rdata),
      .event_in(event_in),
      .lid_in(lid_in),
      .sleeping(sleeping),
      .power_mgmt_interrupt(power_mgmt_interrupt),
      .wake_request(wake_request)
   );

   // ----------------------------------------
   // Byte access tasks
   // ----------------------------------------
   task automatic io_access(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge clock);
      #1;
      io_req.addr = a;
      io_req.wdata = d;
      io_req.wr = w;
      io_req.rd = ~w;
      @(posedge clock);
      #1;
      io_req.wr = 1'b0;
      io_req.rd = 1'b0;
      rd_val = io_rdata;
   endtask : io_access

   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      io_access(a, d, 1'b1);
   endtask : io_write

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask : chk

   task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] exp);
      io_access(a, 8'h00, 1'b0);
      chk(name, exp, rd_val);
   endtask : rchk

   task automatic settle();
      repeat (8) @(posedge clock);
      #1;
   endtask : settle

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clock);
      #1;
      rst_b = 1'b1;
      rchk("status0", 16'h0020, 8'h00);
      rchk("enable0", 16'h0021, 8'h00);
      rchk("status1", 16'h0024, 8'h00);
      rchk("enable1", 16'h0025, 8'h00);
      rchk("lid", 16'h0200, 8'h00);
      $display("test reset values done");
      io_write(16'h0021, 8'h5a);
      io_write(16'h0025, 8'ha5);
      io_write(16'h0022, 8'hff);
      rchk("enable0", 16'h0021, 8'h5a);
      rchk("enable1", 16'h0025, 8'ha5);
      rchk("unmapped", 16'h0022, 8'h00);
      rchk("status0", 16'h0020, 8'h00);
      io_write(16'h0021, 8'h00);
      io_write(16'h0025, 8'h00);
      $display("test byte access done");
      pins_set = 16'hffff;
      settle();
      rchk("status0", 16'h0020, 8'hfd);
      rchk("status1", 16'h0024, 8'hff);
      chk("irq", 8'h00, {7'h00, power_mgmt_interrupt});
      io_write(16'h0021, 8'h01);
      settle();
      chk("irq", 8'h01, {7'h00, power_mgmt_interrupt});
      pins_set = 16'h0000;
      io_write(16'h0020, 8'h00);
      rchk("status0", 16'h0020, 8'hfd);
      io_write(16'h0020, 8'h05);
      settle();
      rchk("status0", 16'h0020, 8'hf8);
      chk("irq", 8'h00, {7'h00, power_mgmt_interrupt});
      $display("test events done");
      sleeping = 1'b1;
      io_write(16'h0025, 8'h80);
      settle();
      chk("wake", 8'h01, {7'h00, wake_request});
      chk("irq", 8'h01, {7'h00, power_mgmt_interrupt});
      io_write(16'h0024, 8'h80);
      settle();
      chk("wake", 8'h00, {7'h00, wake_request});
      sleeping = 1'b0;
      io_write(16'h0025, 8'h00);
      $display("test wake done");
      lid_open = 1'b0;
      settle();
      rchk("lid", 16'h0200, 8'h02);
      rchk("status0", 16'h0020, 8'hfa);
      io_write(16'h0200, 8'h01);
      io_write(16'h0200, 8'h03);
      io_write(16'h0020, 8'h02);
      settle();
      rchk("lid", 16'h0200, 8'h01);
      rchk("status0", 16'h0020, 8'hf8);
      lid_open = 1'b1;
      settle();
      rchk("lid", 16'h0200, 8'h03);
      $display("test lid done");
      finish_test();
   end

   initial
   begin
      #20000;
      failures++;
      finish_test();
   end
endmodule : testbench
